// [acs_pkg.sv]
// Shared constants and carriers for the converter sequencer.
// Assumes one system clock; all timing counts are in half converter cycles.
package acs_pkg;

  // ---------------------------------------------------------------
  // Register map (byte offsets on APB)
  // ---------------------------------------------------------------
  localparam logic [7:0] ACS_CTRL_OFS = 8'h00;
  localparam logic [7:0] ACS_SEL_OFS  = 8'h04;
  localparam logic [7:0] ACS_STAT_OFS = 8'h08;
  localparam logic [7:0] ACS_DATA_OFS = 8'h0C;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int ACS_CTRL_EN_POS    = 0;
  localparam int ACS_CTRL_START_POS = 1;
  localparam int ACS_CTRL_AUTO_POS  = 2;
  localparam int ACS_CTRL_FREE_POS  = 3;
  localparam int ACS_CTRL_IE_POS    = 4;
  localparam int ACS_CTRL_PS_POS    = 8;
  localparam int ACS_SEL_CH_POS     = 0;
  localparam int ACS_SEL_REF_POS    = 6;
  localparam int ACS_STAT_DONE_POS  = 0;
  localparam int ACS_STAT_BUSY_POS  = 1;
  localparam int ACS_STAT_SYNC_POS  = 2;
  localparam int ACS_STAT_FIRST_POS = 3;

  // ---------------------------------------------------------------
  // Reset values and codes
  // ---------------------------------------------------------------
  localparam logic [2:0]  ACS_PS_RST      = 3'h1;
  localparam logic [4:0]  ACS_CH_RST      = 5'h00;
  localparam logic [1:0]  ACS_REF_RST     = 2'h0;
  localparam logic [4:0]  ACS_DIFF_BASE   = 5'h08;
  localparam logic [1:0]  ACS_REF_PIN     = 2'h0;
  localparam logic [1:0]  ACS_REF_SUPPLY  = 2'h1;
  localparam logic [1:0]  ACS_REF_INT     = 2'h3;
  localparam logic [9:0]  ACS_FULL_SCALE  = 10'h3FF;

  // ---------------------------------------------------------------
  // Conversion timing, in half converter clock cycles from start (unlock lead: before done)
  // ---------------------------------------------------------------
  localparam logic [5:0] ACS_FIRST_SH   = 6'd29;
  localparam logic [5:0] ACS_FIRST_DONE = 6'd50;
  localparam logic [5:0] ACS_NORM_SH    = 6'd3;
  localparam logic [5:0] ACS_NORM_DONE  = 6'd26;
  localparam logic [5:0] ACS_AUTO_SH    = 6'd4;
  localparam logic [5:0] ACS_AUTO_DONE  = 6'd27;
  localparam logic [5:0] ACS_DIFF_SH    = 6'd5;
  localparam logic [5:0] ACS_DIFF_DONE  = 6'd28;
  localparam logic [5:0] ACS_UNLOCK_LEAD = 6'd2;

  typedef enum logic [1:0] {ACS_IDLE, ACS_PEND, ACS_CONV} acs_state_t;

  typedef struct packed {
    logic [4:0] channel;
    logic [1:0] reference;
  } acs_sel_t;

endpackage : acs_pkg

// [acs_prescaler.sv]
// Converter clock prescaler: half-cycle tick enable from the system clock.
// Assumes the caller gates it with the clock enable and a clear.
`timescale 1ns/1ps
module acs_prescaler #(
  parameter int W = 8
) (
  input  wire logic         sys_clk,
  input  wire logic         rst,
  input  wire logic         clk_en,
  input  wire logic         clear,
  input  wire logic [2:0]   div_sel,
  output logic              half_tick
);

  typedef struct packed {
    logic [W-1:0] count;
  } acs_ps_state_t;

  acs_ps_state_t st;
  acs_ps_state_t next_st;
  logic [W-1:0]  mask;

  always_comb begin
    mask = W'((1 << div_sel) - 1);
    half_tick = !clear && ((st.count & mask) == mask);
    next_st = st;
    if (clear) begin
      next_st.count = '0;
    end else begin
      next_st.count = st.count + W'(1);
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

endmodule : acs_prescaler

// [acs_sequencer.sv]
// Conversion sequencer for a successive-approximation converter, APB slave.
// Assumes the analog core returns its code on sar_result at conversion end.
//
// Overview of operation
// - First conversion 14.5/25 cycles; normal 1.5/13; auto-triggered 2/13.5.
// - Differential user starts take 13 cycles if sync clock low, else 14.
// - Free running differential restarts take 14 cycles, but 25 when restarting after the first conversion.
// - Selection buffered; active copy tracks buffer until start, then frozen.
// - Active selection resumes tracking in last converter cycle before done.
// - Start at next rising converter edge; software waits a cycle to reselect.
// - Free running: conversion under way keeps the previous channel.
// - Reference field picks supply, internal 2.56V or external pin.
// - Single-ended overrange gives full scale code 0x3FF.
// - Noise sleep starts a conversion once the processor has halted, if interrupt enabled and not auto-triggered.
// - Completion raises interrupt request even if already woken.
// - Other sleep modes never disable the converter automatically.
// - Completion stores result, sets done flag, clears start in single mode.
// - Free running restarts at once, start bit stays set.
//
// Design decisions made here: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module acs_sequencer #(
  parameter int PS_W = 8
) (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        clk_en,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Trigger and sleep controller
  input  wire logic        trigger_in,
  input  wire logic        cpu_halted,
  input  wire logic        sleep_quiet_mode,
  // Analog core
  input  wire logic [9:0]  sar_result,
  input  wire logic        sar_overrange,
  output logic             sample_hold,
  output logic             conv_active,
  output logic [4:0]       channel_select_field,
  output logic [2:0]       ref_source_onehot,
  output logic             irq_request
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    // control_status_a_reg
    logic                converter_enable_bit;
    logic                conversion_start_bit;
    logic                auto_trigger_enable_bit;
    logic                free_run;
    logic                irq_enable;
    logic [2:0]          prescale;
    logic                conversion_done_flag;
    // channel_ref_select_reg: buffer and active copy
    acs_pkg::acs_sel_t   buf_sel;
    acs_pkg::acs_sel_t   act_sel;
    logic                locked;
    logic [9:0]          result;
    acs_pkg::acs_state_t state;
    logic [5:0]          half_cnt;
    logic [5:0]          sh_at;
    logic [5:0]          done_at;
    logic                first_pending;
    logic                half_phase;
    logic                half_rate_sync_clock;
    logic                trig_prev;
    logic                sleep_armed;
    logic                pend_auto;
    // Registered outputs
    logic [31:0]         rdata;
    logic                ready;
    logic                slverr;
    logic                sh_pulse;
    logic [2:0]          ref_oh;
    logic                irq;
  } acs_state_all_t;

  acs_state_all_t st;
  acs_state_all_t next_st;

  logic       half_tick;
  logic       ps_clear;
  logic       full_edge;
  logic       trig_edge;
  logic       bus_acc;
  logic       is_diff;
  logic       start_now;
  logic       auto_start;
  logic       sleep_start;
  logic       finish;
  logic       restart;
  logic [9:0] capture;

  // Prescaler is cleared while disabled and on a trigger edge
  assign trig_edge = st.converter_enable_bit && st.auto_trigger_enable_bit
                     && !st.free_run && trigger_in && !st.trig_prev
                     && (st.state == acs_pkg::ACS_IDLE);
  assign ps_clear  = !st.converter_enable_bit || trig_edge;

  acs_prescaler #(
    .W         (PS_W)
  ) i_acs_prescaler (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .clk_en    (clk_en),
    .clear     (ps_clear),
    .div_sel   (st.prescale),
    .half_tick (half_tick)
  );

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    next_st   = st;
    bus_acc   = psel && penable && st.ready;
    full_edge = half_tick && st.half_phase;
    is_diff   = st.buf_sel.channel >= acs_pkg::ACS_DIFF_BASE;
    finish    = (st.state == acs_pkg::ACS_CONV) && half_tick
                && (st.half_cnt + 6'd1 == st.done_at);
    restart   = finish && st.free_run && st.auto_trigger_enable_bit;
    start_now = (st.state == acs_pkg::ACS_PEND) && full_edge;
    auto_start = trig_edge;
    sleep_start = st.converter_enable_bit && st.sleep_armed && cpu_halted
                  && sleep_quiet_mode && st.irq_enable
                  && !st.auto_trigger_enable_bit
                  && (st.state == acs_pkg::ACS_IDLE)
                  && !st.conversion_start_bit;
    capture   = (sar_overrange && !(st.act_sel.channel >= acs_pkg::ACS_DIFF_BASE))
                ? acs_pkg::ACS_FULL_SCALE : sar_result;

    next_st.trig_prev = trigger_in;
    next_st.sh_pulse  = 1'b0;

    // Converter clock phase and half-rate sync clock
    if (!st.converter_enable_bit || trig_edge) begin
      next_st.half_phase = 1'b0;
    end else if (half_tick) begin
      next_st.half_phase = !st.half_phase;
    end
    if (!st.converter_enable_bit) begin
      next_st.half_rate_sync_clock = 1'b0;
    end else if (full_edge) begin
      next_st.half_rate_sync_clock = !st.half_rate_sync_clock;
    end

    // Sleep arming: one automatic conversion per halt
    if (!cpu_halted) begin
      next_st.sleep_armed = 1'b1;
    end else if (sleep_start) begin
      next_st.sleep_armed = 1'b0;
    end

    // Active selection follows the buffer while unlocked and enabled
    if (!st.locked && st.converter_enable_bit) begin
      next_st.act_sel = st.buf_sel;
    end

    case (st.state)
      acs_pkg::ACS_IDLE: begin
        if (auto_start) begin
          next_st.state     = acs_pkg::ACS_CONV;
          next_st.pend_auto = 1'b1;
        end else if ((st.conversion_start_bit || sleep_start)
                     && st.converter_enable_bit) begin
          next_st.state     = acs_pkg::ACS_PEND;
          next_st.pend_auto = 1'b0;
        end
        if (sleep_start) begin
          next_st.conversion_start_bit = 1'b1;
        end
      end
      acs_pkg::ACS_PEND: begin
        if (start_now) begin
          next_st.state = acs_pkg::ACS_CONV;
        end
      end
      acs_pkg::ACS_CONV: begin
        if (half_tick) begin
          next_st.half_cnt = st.half_cnt + 6'd1;
          if (st.half_cnt + 6'd1 == st.sh_at) begin
            next_st.sh_pulse = 1'b1;
          end
          if (st.half_cnt + 6'd1 == st.done_at - acs_pkg::ACS_UNLOCK_LEAD) begin
            next_st.locked = 1'b0;
          end
        end
        if (finish) begin
          next_st.result               = capture;
          next_st.conversion_done_flag = 1'b1;
          next_st.first_pending        = 1'b0;
          if (restart) begin
            next_st.state = acs_pkg::ACS_CONV;
          end else begin
            next_st.state                = acs_pkg::ACS_IDLE;
            next_st.conversion_start_bit = 1'b0;
          end
        end
      end
      default: begin
        next_st.state = acs_pkg::ACS_IDLE;
      end
    endcase

    // Conversion start: lock selection and choose the timing profile
    if ((st.state == acs_pkg::ACS_IDLE && auto_start) || start_now || restart) begin
      next_st.locked   = 1'b1;
      next_st.half_cnt = 6'd0;
      if (!(st.state == acs_pkg::ACS_CONV)) begin
        next_st.act_sel = st.buf_sel;
      end
      // on a free running restart the copy taken during unlock is used
      if (st.first_pending) begin
        next_st.sh_at   = acs_pkg::ACS_FIRST_SH;
        next_st.done_at = acs_pkg::ACS_FIRST_DONE;
      end else if (is_diff && (restart || st.half_rate_sync_clock)) begin
        next_st.sh_at   = acs_pkg::ACS_DIFF_SH;
        next_st.done_at = acs_pkg::ACS_DIFF_DONE;
      end else if (auto_start) begin
        next_st.sh_at   = acs_pkg::ACS_AUTO_SH;
        next_st.done_at = acs_pkg::ACS_AUTO_DONE;
      end else begin
        next_st.sh_at   = acs_pkg::ACS_NORM_SH;
        next_st.done_at = acs_pkg::ACS_NORM_DONE;
      end
    end

    // Disable aborts any conversion and re-arms the long first conversion
    if (!st.converter_enable_bit) begin
      next_st.state         = acs_pkg::ACS_IDLE;
      next_st.locked        = 1'b0;
      next_st.first_pending = 1'b1;
    end

    // APB: one wait state, then the access completes
    next_st.ready  = psel && penable && !st.ready;
    next_st.slverr = 1'b0;
    next_st.rdata  = 32'h0000_0000;
    if (psel && penable && !st.ready) begin
      case (paddr)
        acs_pkg::ACS_CTRL_OFS: begin
          next_st.rdata[acs_pkg::ACS_CTRL_EN_POS]    = st.converter_enable_bit;
          next_st.rdata[acs_pkg::ACS_CTRL_START_POS] = st.conversion_start_bit;
          next_st.rdata[acs_pkg::ACS_CTRL_AUTO_POS]  = st.auto_trigger_enable_bit;
          next_st.rdata[acs_pkg::ACS_CTRL_FREE_POS]  = st.free_run;
          next_st.rdata[acs_pkg::ACS_CTRL_IE_POS]    = st.irq_enable;
          next_st.rdata[acs_pkg::ACS_CTRL_PS_POS +: 3] = st.prescale;
        end
        acs_pkg::ACS_SEL_OFS: begin
          next_st.rdata[acs_pkg::ACS_SEL_CH_POS +: 5]  = st.buf_sel.channel;
          next_st.rdata[acs_pkg::ACS_SEL_REF_POS +: 2] = st.buf_sel.reference;
        end
        acs_pkg::ACS_STAT_OFS: begin
          next_st.rdata[acs_pkg::ACS_STAT_DONE_POS]  = st.conversion_done_flag;
          next_st.rdata[acs_pkg::ACS_STAT_BUSY_POS]  = st.state != acs_pkg::ACS_IDLE;
          next_st.rdata[acs_pkg::ACS_STAT_SYNC_POS]  = st.half_rate_sync_clock;
          next_st.rdata[acs_pkg::ACS_STAT_FIRST_POS] = st.first_pending;
        end
        acs_pkg::ACS_DATA_OFS: begin
          next_st.rdata[9:0] = st.result;
        end
        default: begin
          next_st.slverr = 1'b1;
        end
      endcase
    end

    if (bus_acc && pwrite) begin
      case (paddr)
        acs_pkg::ACS_CTRL_OFS: begin
          // only software ever clears the enable
          next_st.converter_enable_bit    = pwdata[acs_pkg::ACS_CTRL_EN_POS];
          next_st.auto_trigger_enable_bit = pwdata[acs_pkg::ACS_CTRL_AUTO_POS];
          next_st.free_run                = pwdata[acs_pkg::ACS_CTRL_FREE_POS];
          next_st.irq_enable              = pwdata[acs_pkg::ACS_CTRL_IE_POS];
          next_st.prescale                = pwdata[acs_pkg::ACS_CTRL_PS_POS +: 3];
          // Writing zero never aborts; hardware owns the clear
          if (pwdata[acs_pkg::ACS_CTRL_START_POS] && pwdata[acs_pkg::ACS_CTRL_EN_POS]) begin
            next_st.conversion_start_bit = 1'b1;
          end
        end
        acs_pkg::ACS_SEL_OFS: begin
          next_st.buf_sel.channel   = pwdata[acs_pkg::ACS_SEL_CH_POS +: 5];
          next_st.buf_sel.reference = pwdata[acs_pkg::ACS_SEL_REF_POS +: 2];
        end
        acs_pkg::ACS_STAT_OFS: begin
          // Write one to clear; a completion in the same cycle wins
          if (pwdata[acs_pkg::ACS_STAT_DONE_POS] && !finish) begin
            next_st.conversion_done_flag = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    // Reference source decode
    case (st.act_sel.reference)
      acs_pkg::ACS_REF_PIN:    next_st.ref_oh = 3'h1;
      acs_pkg::ACS_REF_SUPPLY: next_st.ref_oh = 3'h2;
      acs_pkg::ACS_REF_INT:    next_st.ref_oh = 3'h4;
      default:                 next_st.ref_oh = 3'h1;
    endcase

    // Request stays raised until the flag is cleared, even after wake-up
    next_st.irq = next_st.conversion_done_flag && next_st.irq_enable;
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st                   <= '0;
      st.prescale          <= acs_pkg::ACS_PS_RST;
      st.buf_sel.channel   <= acs_pkg::ACS_CH_RST;
      st.buf_sel.reference <= acs_pkg::ACS_REF_RST;
      st.act_sel.channel   <= acs_pkg::ACS_CH_RST;
      st.act_sel.reference <= acs_pkg::ACS_REF_RST;
      st.state             <= acs_pkg::ACS_IDLE;
      st.first_pending     <= 1'b1;
      st.ref_oh            <= 3'h1;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  assign prdata               = st.rdata;
  assign pready               = st.ready;
  assign pslverr              = st.slverr;
  assign sample_hold          = st.sh_pulse;
  assign conv_active          = st.locked;
  assign channel_select_field = st.act_sel.channel;
  assign ref_source_onehot    = st.ref_oh;
  assign irq_request          = st.irq;

endmodule : acs_sequencer

// [acs_sequencer_assertions.sv]
// Port checker for the conversion sequencer.
// Assumes it is bound onto every acs_sequencer instance.
`timescale 1ns/1ps
module acs_sequencer_assertions (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata,
  input wire logic        sample_hold,
  input wire logic        conv_active,
  input wire logic [4:0]  channel_select_field,
  input wire logic [2:0]  ref_source_onehot
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  // ---------------------------------------------------------------
  // Sequences and properties
  // ---------------------------------------------------------------
  sequence s_access_open;
    psel && penable && !$past(penable);
  endsequence
  sequence s_lock_start;
    $rose(conv_active);
  endsequence
  property p_apb_wait;
    s_access_open |-> !pready ##1 pready;
  endproperty
  property p_pready_pulse;
    pready |=> !pready;
  endproperty
  property p_err_answer;
    pslverr |-> pready && prdata == 32'h0000_0000;
  endproperty
  property p_ref_onehot;
    $onehot(ref_source_onehot);
  endproperty
  property p_sh_pulse;
    sample_hold |=> !sample_hold;
  endproperty
  property p_sh_locked;
    sample_hold |-> conv_active;
  endproperty
  property p_lock_frozen;
    conv_active && $past(conv_active)
      |-> $stable(channel_select_field) && $stable(ref_source_onehot);
  endproperty
  property p_lock_min;
    s_lock_start |-> conv_active [*8];
  endproperty
  // Bound covers the longest conversion at the slowest prescale the bench uses
  property p_lock_max;
    s_lock_start |-> ##[8:400] !conv_active;
  endproperty

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  a_apb_wait: assert property (p_apb_wait)
    else $error("apb answer not after one wait state");
  a_pready_pulse: assert property (p_pready_pulse)
    else $error("pready longer than one cycle");
  a_err_answer: assert property (p_err_answer)
    else $error("error answer malformed");
  a_ref_onehot: assert property (p_ref_onehot)
    else $error("reference source not one-hot");
  a_sh_pulse: assert property (p_sh_pulse)
    else $error("sample pulse longer than one cycle");
  a_sh_locked: assert property (p_sh_locked)
    else $error("sample outside locked span");
  a_lock_frozen: assert property (p_lock_frozen)
    else $error("selection moved while locked");
  a_lock_min: assert property (p_lock_min)
    else $error("conversion lock too short");
  a_lock_max: assert property (p_lock_max)
    else $error("conversion lock never released");
endmodule : acs_sequencer_assertions

bind acs_sequencer acs_sequencer_assertions i_acs_sequencer_assertions (
  .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .prdata(prdata), .sample_hold(sample_hold),
  .conv_active(conv_active), .channel_select_field(channel_select_field),
  .ref_source_onehot(ref_source_onehot)
);

// [acs_sequencer_test.sv]
// Self-checking bench for the conversion sequencer over APB.
// Assumes the prescale code stays at its reset value: a half cycle is two clocks.
`timescale 1ns/1ps
module acs_sequencer_test;
  localparam int H = 2;
  logic        sys_clk = 1'h0;
  logic        rst = 1'h1;
  logic        clk_en = 1'h1;
  logic        psel = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic        trigger_in = 1'h0;
  logic        cpu_halted = 1'h0;
  logic        sleep_quiet_mode = 1'h0;
  logic [9:0]  sar_result = 10'h155;
  logic        sar_overrange = 1'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        sample_hold;
  logic        conv_active;
  logic [4:0]  channel_select_field;
  logic [2:0]  ref_source_onehot;
  logic        irq_request;
  logic [31:0] rd;
  logic        err;
  int          fail_count = 0;
  int          checked = 0;
  int          s_at;
  int          l_len;

  always #2 sys_clk = ~sys_clk;

  acs_sequencer i_acs_sequencer (
    .sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .trigger_in(trigger_in), .cpu_halted(cpu_halted),
    .sleep_quiet_mode(sleep_quiet_mode), .sar_result(sar_result),
    .sar_overrange(sar_overrange), .sample_hold(sample_hold), .conv_active(conv_active),
    .channel_select_field(channel_select_field), .ref_source_onehot(ref_source_onehot),
    .irq_request(irq_request)
  );

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : cmp

  // Entered just after a rising edge; one idle edge at the end keeps drives apart
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'h1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'h1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    rd = prdata;
    err = pslverr;
    if (n >= 20) cmp(32'h0, 32'h1, "apb timeout");
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge sys_clk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'h1, d);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    apb(a, 1'h0, 32'h0000_0000);
    cmp(rd, exp, what);
  endtask : rd_chk

  // Both counts start at the edge where the lock is first seen
  task automatic measure();
    int n;
    n = 0;
    s_at = -1;
    l_len = 0;
    while (conv_active !== 1'h1 && n < 500) begin
      @(posedge sys_clk);
      n++;
    end
    while (conv_active === 1'h1 && l_len < 500) begin
      if (sample_hold === 1'h1) s_at = l_len;
      @(posedge sys_clk);
      l_len++;
    end
  endtask : measure

  task automatic chk_conv(input int sh, input int dn);
    repeat (2 * H) @(posedge sys_clk);
    cmp(s_at, sh * H, "sample point");
    cmp(l_len, (dn - acs_pkg::ACS_UNLOCK_LEAD) * H, "locked span");
  endtask : chk_conv

  task automatic start_conv(input logic [31:0] ctrl, input int sh, input int dn);
    fork
      measure();
      wr(acs_pkg::ACS_CTRL_OFS, ctrl);
    join
    chk_conv(sh, dn);
  endtask : start_conv

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : print_verdict

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    cmp(ref_source_onehot, 3'h1, "reset reference");
    rd_chk(acs_pkg::ACS_CTRL_OFS, 32'h0000_0100, "ctrl reset");
    wr(8'h10, 32'hFFFF_FFFF);
    cmp(err, 1'h1, "unmapped write");
    rd_chk(8'h10, 32'h0000_0000, "unmapped read");
    cmp(err, 1'h1, "unmapped read error");
    $display("test reset done");
  endtask : t_reset

  task automatic t_select();
    logic [2:0] exp_ref [4] = '{3'h1, 3'h2, 3'h1, 3'h4};
    wr(acs_pkg::ACS_CTRL_OFS, 32'h0000_0101);
    for (int r = 0; r < 4; r++) begin
      wr(acs_pkg::ACS_SEL_OFS, 32'(r * 64 + 3));
      rd_chk(acs_pkg::ACS_SEL_OFS, 32'(r * 64 + 3), "select readback");
      cmp(ref_source_onehot, exp_ref[r], "reference code");
      cmp(channel_select_field, 5'h03, "channel tracks");
    end
    $display("test select done");
  endtask : t_select

  task automatic t_first();
    start_conv(32'h0000_0103, acs_pkg::ACS_FIRST_SH, acs_pkg::ACS_FIRST_DONE);
    rd_chk(acs_pkg::ACS_DATA_OFS, 32'h0000_0155, "result");
    rd_chk(acs_pkg::ACS_CTRL_OFS, 32'h0000_0101, "start cleared");
    apb(acs_pkg::ACS_STAT_OFS, 1'h0, 32'h0000_0000);
    cmp(rd[0], 1'h1, "done flag");
    wr(acs_pkg::ACS_STAT_OFS, 32'h0000_0001);
    $display("test first done");
  endtask : t_first

  task automatic t_lock();
    fork
      measure();
      begin
        wr(acs_pkg::ACS_CTRL_OFS, 32'h0000_0103);
        repeat (8) @(posedge sys_clk);
        wr(acs_pkg::ACS_SEL_OFS, 32'h0000_0045);
        cmp(channel_select_field, 5'h03, "channel frozen");
      end
    join
    chk_conv(acs_pkg::ACS_NORM_SH, acs_pkg::ACS_NORM_DONE);
    cmp(channel_select_field, 5'h05, "channel after unlock");
    wr(acs_pkg::ACS_STAT_OFS, 32'h0000_0001);
    $display("test lock done");
  endtask : t_lock

  task automatic t_over();
    sar_overrange <= 1'h1;
    sar_result <= 10'h012;
    start_conv(32'h0000_0113, acs_pkg::ACS_NORM_SH, acs_pkg::ACS_NORM_DONE);
    rd_chk(acs_pkg::ACS_DATA_OFS, 32'h0000_03FF, "overrange code");
    cmp(irq_request, 1'h1, "irq after done");
    wr(acs_pkg::ACS_STAT_OFS, 32'h0000_0001);
    apb(acs_pkg::ACS_STAT_OFS, 1'h0, 32'h0000_0000);
    cmp(irq_request, 1'h0, "irq cleared");
    sar_overrange <= 1'h0;
    $display("test overrange done");
  endtask : t_over

  // Processor is woken by something else a third of the way through the conversion
  task automatic t_sleep();
    fork
      measure();
      begin
        cpu_halted <= 1'h1;
        sleep_quiet_mode <= 1'h1;
        repeat (20) @(posedge sys_clk);
        cpu_halted <= 1'h0;
        sleep_quiet_mode <= 1'h0;
      end
    join
    chk_conv(acs_pkg::ACS_NORM_SH, acs_pkg::ACS_NORM_DONE);
    rd_chk(acs_pkg::ACS_DATA_OFS, 32'h0000_0012, "sleep result");
    cmp(irq_request, 1'h1, "late wake request");
    wr(acs_pkg::ACS_STAT_OFS, 32'h0000_0001);
    cpu_halted <= 1'h1;
    repeat (16) @(posedge sys_clk);
    rd_chk(acs_pkg::ACS_CTRL_OFS, 32'h0000_0111, "enable kept");
    cpu_halted <= 1'h0;
    $display("test sleep done");
  endtask : t_sleep

  task automatic t_auto();
    wr(acs_pkg::ACS_CTRL_OFS, 32'h0000_0105);
    fork
      measure();
      trigger_in <= 1'h1;
    join
    chk_conv(acs_pkg::ACS_AUTO_SH, acs_pkg::ACS_AUTO_DONE);
    trigger_in <= 1'h0;
    wr(acs_pkg::ACS_CTRL_OFS, 32'h0000_0101);
    $display("test auto done");
  endtask : t_auto

  task automatic t_free();
    wr(acs_pkg::ACS_SEL_OFS, 32'h0000_0048);
    start_conv(32'h0000_010F, acs_pkg::ACS_DIFF_SH, acs_pkg::ACS_DIFF_DONE);
    fork
      measure();
      begin
        wr(acs_pkg::ACS_SEL_OFS, 32'h0000_0049);
        cmp(channel_select_field, 5'h08, "channel under way");
      end
    join
    chk_conv(acs_pkg::ACS_DIFF_SH, acs_pkg::ACS_DIFF_DONE);
    cmp(channel_select_field, 5'h09, "channel for next");
    rd_chk(acs_pkg::ACS_CTRL_OFS, 32'h0000_010F, "start held");
    wr(acs_pkg::ACS_CTRL_OFS, 32'h0000_0100);
    $display("test free run done");
  endtask : t_free

  initial begin
    repeat (12) @(posedge sys_clk);
    rst <= 1'h0;
    @(posedge sys_clk);
    t_reset();
    t_select();
    t_first();
    t_lock();
    t_over();
    t_sleep();
    t_auto();
    t_free();
    print_verdict();
  end

  // The whole sequence needs well under 3000 clocks
  initial begin
    repeat (10000) @(posedge sys_clk);
    fail_count++;
    $display("unexpected at %0t: watchdog expired", $time);
    print_verdict();
  end
endmodule : acs_sequencer_test
